// >>> psr_bank.sv
// Processor-status register bank of one tile, answering status reads and
// writes from the local core by register number.
// Assumes one request at a time from a core on sys_clk_i; oscillator and
// boot-mode pins arrive asynchronously and are synchronised here.
//
// What this block does
// RULE1: RAM base resets to 0x00010000
// RULE2: RAM base keeps bits 31:2, low bits zero
// RULE3: Vector address is vector-base high plus event vector
// RULE4: Tile control bit 4 enables clock divider
// RULE5: Bit 5 dynamic: divide only when cores paused
// RULE6: Boot status 23:16 shows tile number
// RULE7: Boot status bit 8 shows OTP boot
// RULE8: Boot status 7:0 shows sampled mode pins
// RULE9: Security register copies OTP word, read-only
// RULE10: Oscillator control bits enable tile, peripheral rings
// RULE11: Four oscillators each drive a gated counter
// RULE12: Software reads counters only when stopped
// RULE13: Registers 0x07-0x0a return 16-bit counts
// RULE14: Counters keep counts through reset
// RULE15: Oscillators asynchronous to tile clock
// RULE16: Register 0x10 holds saved status at debug entry
// RULE17: Access only via status read/write by number
// RULE18: Core forms identifier as number shl 8 or 0x0c
// RULE19: Counter values synchronised into tile clock
// RULE20: Reserved bits zero, read-only writes ignored
`timescale 1ns/1ns
module psr_bank #(
   parameter int DIV_RATIO = psr_pkg::DIV_RATIO_DEF
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   // Status access port from the core
   input wire logic ps_rd_i,
   input wire logic ps_wr_i,
   input wire logic [7:0] ps_num_i,
   input wire logic [31:0] ps_wdata_i,
   output logic ps_ack_o,
   output logic ps_miss_o,
   output logic [31:0] ps_rdata_o,
   // Event vector formation
   input wire logic event_req_i,
   input wire logic [15:0] event_vec_i,
   output logic dest_valid_o,
   output logic [31:0] dest_addr_o,
   // Clock divider
   input wire logic all_paused_i,
   output logic tile_clk_en_o,
   output logic clk_slow_o,
   // Boot and security inputs
   input wire logic [7:0] tile_number_i,
   input wire logic otp_boot_en_i,
   input wire logic [psr_pkg::BOOT_MODE_W-1:0] boot_mode_pin_i,
   input wire logic security_load_i,
   input wire logic [31:0] security_word_i,
   // Ring oscillators
   input wire logic [psr_pkg::OSC_NUM-1:0] osc_wave_i,
   output logic [psr_pkg::OSC_NUM-1:0] osc_run_o,
   // Debug entry
   input wire logic debug_entry_i,
   input wire logic [31:0] saved_status_word_i
);
   // ==========================================================
   // Address decode
   function automatic logic psr_mapped(input logic [7:0] num);
      psr_mapped = (num <= psr_pkg::REG_OSC_CNT3 && num != 8'h04) ||
                   (num == psr_pkg::REG_DBG_SAVED);
   endfunction

   // ==========================================================
   // State
   logic [31:psr_pkg::RAM_BASE_LSB] ram_base;
   logic [31:psr_pkg::VEC_BASE_LSB] vec_base;
   logic [1:0] tile_ctl;
   logic [1:0] osc_ctl;
   logic [31:0] sec_word;
   logic [31:0] saved_copy;
   logic [psr_pkg::BOOT_MODE_W-1:0] mode_s1, mode_s2, boot_mode;
   logic [1:0] settle;
   logic [31:psr_pkg::RAM_BASE_LSB] next_ram_base;
   logic [31:psr_pkg::VEC_BASE_LSB] next_vec_base;
   logic [1:0] next_tile_ctl;
   logic [1:0] next_osc_ctl;
   logic [31:0] next_sec_word;
   logic [31:0] next_saved_copy;
   logic [psr_pkg::BOOT_MODE_W-1:0] next_boot_mode;
   logic [1:0] next_settle;
   logic wr_ram, wr_vec, wr_tile, wr_osc;
   logic [psr_pkg::OSC_CNT_W-1:0] osc_cnt [psr_pkg::OSC_NUM];
   logic [psr_pkg::OSC_NUM-1:0] osc_en;

   // ==========================================================
   // Configuration registers
   // Writes to read-only numbers fall through with no effect
   always_comb begin
      wr_ram = ps_wr_i && ps_num_i == psr_pkg::REG_RAM_BASE;
      wr_vec = ps_wr_i && ps_num_i == psr_pkg::REG_VEC_BASE;
      wr_tile = ps_wr_i && ps_num_i == psr_pkg::REG_TILE_CTL;
      wr_osc = ps_wr_i && ps_num_i == psr_pkg::REG_OSC_CTL; // RULE17
      next_ram_base = wr_ram ? ps_wdata_i[31:psr_pkg::RAM_BASE_LSB] : ram_base; // RULE2
      next_vec_base = wr_vec ? ps_wdata_i[31:psr_pkg::VEC_BASE_LSB] : vec_base;
      next_tile_ctl = tile_ctl;
      if (wr_tile) begin
         next_tile_ctl = {ps_wdata_i[psr_pkg::TILE_DYN_BIT],
                          ps_wdata_i[psr_pkg::TILE_DIV_EN_BIT]};
      end
      next_osc_ctl = osc_ctl;
      if (wr_osc) begin // RULE10
         next_osc_ctl = {ps_wdata_i[psr_pkg::OSC_TILE_BIT],
                         ps_wdata_i[psr_pkg::OSC_PERIPH_BIT]};
      end
      next_sec_word = security_load_i ? security_word_i : sec_word; // RULE9
      next_saved_copy = debug_entry_i ? saved_status_word_i : saved_copy; // RULE16
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ram_base <= psr_pkg::RAM_BASE_RST[31:psr_pkg::RAM_BASE_LSB]; // RULE1
         vec_base <= '0;
         tile_ctl <= psr_pkg::TILE_CTL_RST;
         osc_ctl <= psr_pkg::OSC_CTL_RST;
         sec_word <= '0;
         saved_copy <= '0;
      end else begin
         ram_base <= next_ram_base;
         vec_base <= next_vec_base;
         tile_ctl <= next_tile_ctl;
         osc_ctl <= next_osc_ctl;
         sec_word <= next_sec_word;
         saved_copy <= next_saved_copy;
      end
   end

   // ==========================================================
   // Boot-mode pins: synchronised, then caught once after reset release
   // Catching once keeps boot status steady if the straps float later
   always_comb begin
      next_settle = (settle == psr_pkg::BOOT_SETTLE) ? settle : settle + 2'h1;
      next_boot_mode = boot_mode;
      if (settle == psr_pkg::BOOT_SETTLE - 2'h1) begin
         next_boot_mode = mode_s2; // RULE8
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mode_s1 <= '0;
         mode_s2 <= '0;
         boot_mode <= '0;
         settle <= '0;
      end else begin
         mode_s1 <= boot_mode_pin_i;
         mode_s2 <= mode_s1;
         boot_mode <= next_boot_mode;
         settle <= next_settle;
      end
   end

   // ==========================================================
   // Event destination address
   logic next_dest_valid;
   logic [31:0] next_dest_addr;

   always_comb begin
      next_dest_valid = event_req_i;
      next_dest_addr = dest_addr_o;
      if (event_req_i) begin
         next_dest_addr = {vec_base, event_vec_i}; // RULE3
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         dest_valid_o <= 1'b0;
         dest_addr_o <= '0;
      end else begin
         dest_valid_o <= next_dest_valid;
         dest_addr_o <= next_dest_addr;
      end
   end

   // ==========================================================
   // Clock divider
   psr_div_if div_bus ();

   assign div_bus.div_en = tile_ctl[0]; // RULE4
   assign div_bus.dyn_mode = tile_ctl[1]; // RULE5
   assign div_bus.all_paused = all_paused_i;
   assign tile_clk_en_o = div_bus.clk_en;
   assign clk_slow_o = div_bus.div_active;

   psr_clk_div #(
      .DIV_RATIO(DIV_RATIO)
   ) u_div (
      .clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .dv(div_bus.div)
   );

   // ==========================================================
   // Ring oscillators: two tile rings, then two peripheral rings
   // The rings are free-running analog cells; only their enables leave here
   assign osc_en = {osc_ctl[1], osc_ctl[1], osc_ctl[0], osc_ctl[0]}; // RULE11
   assign osc_run_o = osc_en; // RULE15

   for (genvar g = 0; g < psr_pkg::OSC_NUM; g++) begin : g_osc
      psr_osc_counter #(
         .W(psr_pkg::OSC_CNT_W)
      ) u_cnt (
         .clk_i(sys_clk_i),
         .nrst_i(nrst_i),
         .wave_i(osc_wave_i[psr_pkg::OSC_NUM-1-g]),
         .en_i(osc_en[psr_pkg::OSC_NUM-1-g]),
         .count_o(osc_cnt[g])
      );
   end

   // ==========================================================
   // Read response, one cycle after the request
   logic next_ack;
   logic next_miss;
   logic [31:0] next_rdata;

   always_comb begin
      next_ack = ps_rd_i | ps_wr_i;
      next_miss = (ps_rd_i | ps_wr_i) & ~psr_mapped(ps_num_i);
      next_rdata = '0; // RULE20
      if (ps_rd_i && !ps_wr_i) begin
         unique case (ps_num_i)
            psr_pkg::REG_RAM_BASE: next_rdata = {ram_base, 2'h0};
            psr_pkg::REG_VEC_BASE: next_rdata = {vec_base, 16'h0};
            psr_pkg::REG_TILE_CTL: begin
               next_rdata[psr_pkg::TILE_DIV_EN_BIT] = tile_ctl[0];
               next_rdata[psr_pkg::TILE_DYN_BIT] = tile_ctl[1];
            end
            psr_pkg::REG_BOOT_STS: begin
               next_rdata[psr_pkg::BOOT_TILE_LSB +: 8] = tile_number_i; // RULE6
               next_rdata[psr_pkg::BOOT_OTP_BIT] = otp_boot_en_i; // RULE7
               next_rdata[psr_pkg::BOOT_MODE_W-1:0] = boot_mode; // RULE8
            end
            psr_pkg::REG_SEC_WORD: next_rdata = sec_word; // RULE9
            psr_pkg::REG_OSC_CTL: next_rdata[1:0] = osc_ctl;
            8'h07, 8'h08, 8'h09, 8'h0a: begin
               next_rdata[psr_pkg::OSC_CNT_W-1:0] =
                  osc_cnt[2'(ps_num_i - psr_pkg::REG_OSC_CNT0)]; // RULE13
            end
            psr_pkg::REG_DBG_SAVED: next_rdata = saved_copy; // RULE16
            default: next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ps_ack_o <= 1'b0;
         ps_miss_o <= 1'b0;
         ps_rdata_o <= '0;
      end else begin
         ps_ack_o <= next_ack;
         ps_miss_o <= next_miss;
         ps_rdata_o <= next_rdata;
      end
   end

   // ==========================================================
   // Checks
   logic ram_touched;
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ram_touched <= 1'b0;
      end else if (wr_ram) begin
         ram_touched <= 1'b1;
      end
   end

   sequence s_vec_write;
      ps_wr_i && ps_num_i == psr_pkg::REG_VEC_BASE;
   endsequence

   sequence s_vec_read;
      ps_rd_i && !ps_wr_i && ps_num_i == psr_pkg::REG_VEC_BASE;
   endsequence

   a_ram_reset_val: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE1
      !ram_touched |-> {ram_base, 2'h0} == psr_pkg::RAM_BASE_RST)
      else $error("RAM base lost its reset value");

   a_ram_low_zero: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE2
      ps_ack_o && $past(ps_rd_i && ps_num_i == psr_pkg::REG_RAM_BASE)
      |-> ps_rdata_o[1:0] == 2'h0)
      else $error("RAM base low bits not zero");

   a_dest_form: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE3
      event_req_i |=> dest_valid_o &&
      dest_addr_o == {$past(vec_base), $past(event_vec_i)})
      else $error("event destination formed wrongly");

   a_div_static: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE4
      (tile_ctl == 2'h1) ##1 (tile_ctl == 2'h1) |-> clk_slow_o)
      else $error("static divider not applied");

   a_div_dynamic: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE5
      tile_ctl[1] && !all_paused_i |=> !clk_slow_o)
      else $error("dynamic divider applied while cores run");

   a_vec_readback: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE17
      s_vec_write ##1 !ps_wr_i ##1 s_vec_read |=> ps_ack_o &&
      ps_rdata_o == {$past(ps_wdata_i[31:16], 3), 16'h0})
      else $error("vector base readback wrong");

   a_osc_enables: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE10
      wr_osc |=> osc_run_o == {{2{$past(ps_wdata_i[1])}}, {2{$past(ps_wdata_i[0])}}})
      else $error("oscillator enables not taken");

   a_count_upper: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE13
      ps_ack_o && $past(ps_rd_i && ps_num_i >= psr_pkg::REG_OSC_CNT0 &&
      ps_num_i <= psr_pkg::REG_OSC_CNT3) |-> ps_rdata_o[31:16] == 16'h0)
      else $error("count upper bits not zero");

   a_ro_ignored: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE20
      ps_wr_i && ps_num_i == psr_pkg::REG_SEC_WORD && !security_load_i
      |=> $stable(sec_word))
      else $error("write changed read-only register");
endmodule

// >>> psr_pkg.sv
// Shared constants of the processor-status register bank.
// Assumes one tile clock; register numbers are the core's status numbers.
package psr_pkg;
   // ==========================================================
   // Clock
   localparam int CLK_PERIOD_NS = 4;
   localparam int DIV_RATIO_DEF = 4;

   // ==========================================================
   // Register numbers
   localparam logic [7:0] REG_RAM_BASE = 8'h00;
   localparam logic [7:0] REG_VEC_BASE = 8'h01;
   localparam logic [7:0] REG_TILE_CTL = 8'h02;
   localparam logic [7:0] REG_BOOT_STS = 8'h03;
   localparam logic [7:0] REG_SEC_WORD = 8'h05;
   localparam logic [7:0] REG_OSC_CTL = 8'h06;
   localparam logic [7:0] REG_OSC_CNT0 = 8'h07;
   localparam logic [7:0] REG_OSC_CNT3 = 8'h0a;
   localparam logic [7:0] REG_DBG_SAVED = 8'h10;

   // ==========================================================
   // Field layouts and reset values
   localparam logic [31:0] RAM_BASE_RST = 32'h0001_0000;
   localparam int RAM_BASE_LSB = 2;
   localparam int VEC_BASE_LSB = 16;
   localparam int TILE_DIV_EN_BIT = 4;
   localparam int TILE_DYN_BIT = 5;
   localparam logic [1:0] TILE_CTL_RST = 2'h0;
   localparam int BOOT_TILE_LSB = 16;
   localparam int BOOT_OTP_BIT = 8;
   localparam int BOOT_MODE_W = 8;
   localparam int OSC_TILE_BIT = 1;
   localparam int OSC_PERIPH_BIT = 0;
   localparam logic [1:0] OSC_CTL_RST = 2'h0;
   localparam int OSC_NUM = 4;
   localparam int OSC_CNT_W = 16;
   localparam logic [1:0] BOOT_SETTLE = 2'h3;
endpackage

// >>> psr_div_if.sv
// Carrier between the register bank and its clock divider.
// Assumes both ends on the tile clock.
`timescale 1ns/1ns
interface psr_div_if;
   logic div_en;
   logic dyn_mode;
   logic all_paused;
   logic div_active;
   logic clk_en;
   modport bank (output div_en, output dyn_mode, output all_paused,
                 input div_active, input clk_en);
   modport div (input div_en, input dyn_mode, input all_paused,
                output div_active, output clk_en);
endinterface

// >>> psr_osc_counter.sv
// One ring-oscillator counter, counted in the tile clock domain.
// Assumes wave_i is a free-running oscillator output, asynchronous to clk_i.
`timescale 1ns/1ns
module psr_osc_counter #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Oscillator side
   input wire logic wave_i,
   input wire logic en_i,
   // Count
   output logic [W-1:0] count_o
);
   // ==========================================================
   // Elaboration check
   if (W < 2) begin : g_bad_w
      $error("psr_osc_counter: W must be at least 2");
   end

   // ==========================================================
   // Synchroniser and edge detector
   logic sync_a, sync_b, sync_c;
   logic next_sync_a, next_sync_b, next_sync_c;
   logic rise;
   logic [W-1:0] next_count;

   // Second and third stages feed the edge detector, never the first
   always_comb begin
      next_sync_a = wave_i;
      next_sync_b = sync_a;
      next_sync_c = sync_b;
      rise = sync_b & ~sync_c; // RULE19
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         sync_c <= 1'b0;
      end else begin
         sync_a <= next_sync_a;
         sync_b <= next_sync_b;
         sync_c <= next_sync_c;
      end
   end

   // ==========================================================
   // Counter: no reset, so the count outlives a system reset
   // Power-up value only, so the count is defined before its first edge
   logic [W-1:0] tally = '0;

   always_comb begin
      next_count = tally;
      if (en_i && rise) begin
         next_count = tally + W'(1); // RULE11
      end
   end

   always_ff @(posedge clk_i) begin
      tally <= next_count; // RULE14
   end

   assign count_o = tally;

   a_count_frozen: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !en_i |=> $stable(count_o)) else $error("count moved while stopped"); // RULE11
endmodule

// >>> psr_clk_div.sv
// Tile clock divider: emits a clock-enable pulse, slowed when active.
// Assumes the paused flag comes from core logic on the same clock.
`timescale 1ns/1ns
module psr_clk_div #(
   parameter int DIV_RATIO = 4
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Bank side
   psr_div_if.div dv
);
   // ==========================================================
   // Elaboration check
   localparam int CW = (DIV_RATIO < 2) ? 1 : $clog2(DIV_RATIO);
   localparam logic [CW-1:0] LAST = CW'(DIV_RATIO - 1);
   if (DIV_RATIO < 2) begin : g_bad_ratio
      $error("psr_clk_div: DIV_RATIO must be at least 2");
   end

   // ==========================================================
   // Divider state
   logic active;
   logic en_q;
   logic [CW-1:0] cnt;
   logic next_active;
   logic next_en;
   logic [CW-1:0] next_cnt;

   // Dynamic mode only slows while every live core is paused
   always_comb begin
      next_active = dv.div_en & (~dv.dyn_mode | dv.all_paused); // RULE5
      next_cnt = '0;
      next_en = 1'b1;
      if (active) begin // RULE4
         next_cnt = (cnt == LAST) ? '0 : cnt + CW'(1);
         next_en = (cnt == LAST);
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         active <= 1'b0;
         en_q <= 1'b1;
         cnt <= '0;
      end else begin
         active <= next_active;
         en_q <= next_en;
         cnt <= next_cnt;
      end
   end

   assign dv.div_active = active;
   assign dv.clk_en = en_q;
endmodule

// >>> psr_core_model.sv
// ==========================================================
// Model of the local core that issues status reads and writes.
// Assumes the bank answers each request exactly one cycle later.
`timescale 1ns/1ns
module psr_core_model (
   // Clock
   input wire logic sys_clk_i,
   // Status access port
   output logic ps_rd_o,
   output logic ps_wr_o,
   output logic [7:0] ps_num_o,
   output logic [31:0] ps_wdata_o,
   input wire logic ps_ack_i,
   input wire logic ps_miss_i,
   input wire logic [31:0] ps_rdata_i
);
   // Idle port at time zero
   initial begin
      ps_rd_o = 1'b0;
      ps_wr_o = 1'b0;
      ps_num_o = 8'h00;
      ps_wdata_o = 32'h0;
   end

   // One status access; the number travels inside a resource identifier
   task automatic access(input logic wr, input logic [7:0] num, input logic [31:0] wd,
                         output logic [31:0] rd, output logic miss, output logic ack);
      logic [31:0] res_id;
      res_id = ({24'h0, num} << 8) | 32'h0000_000c;
      @(posedge sys_clk_i);
      #1;
      ps_rd_o = !wr;
      ps_wr_o = wr;
      ps_num_o = res_id[15:8];
      ps_wdata_o = wd;
      @(posedge sys_clk_i);
      #1;
      rd = ps_rdata_i;
      miss = ps_miss_i;
      ack = ps_ack_i;
      // Released lines must not keep looking valid
      ps_rd_o = 1'b0;
      ps_wr_o = 1'b0;
      ps_num_o = ~res_id[15:8];
      ps_wdata_o = ~wd;
   endtask
endmodule

// >>> psr_bank_tb_top.sv
// ==========================================================
// Self-checking bench of the processor-status register bank.
// Assumes the core model above and free-running oscillator waves.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module psr_bank_tb_top;
   localparam int DIVR = 4;
   logic sys_clk_i = 1'b0, nrst_i = 1'b0;
   logic ps_rd, ps_wr, ps_ack_o, ps_miss_o, event_req_i = 1'b0, dest_valid_o;
   logic [7:0] ps_num, tile_number_i = 8'h00, boot_mode_pin_i = 8'h00;
   logic [31:0] ps_wdata, ps_rdata_o, dest_addr_o, security_word_i = 32'h0;
   logic [31:0] saved_status_word_i = 32'h0, seed = 32'ha656, d, g;
   logic [15:0] event_vec_i = 16'h0, b[4], a[4];
   logic all_paused_i = 1'b0, tile_clk_en_o, clk_slow_o, otp_boot_en_i = 1'b0;
   logic security_load_i = 1'b0, debug_entry_i = 1'b0, m;
   logic [3:0] osc_wave_i = 4'h0, osc_run_o;
   int err_count = 0, num_checks = 0, cnt;
   logic [7:0] wregs[4] = '{8'h00, 8'h01, 8'h02, 8'h06};
   logic [7:0] holes[4] = '{8'h04, 8'h0b, 8'h0f, 8'h11};

   // Tile clock and four oscillators on unrelated periods
   always #2 sys_clk_i = ~sys_clk_i;
   always #11 osc_wave_i[3] = ~osc_wave_i[3];
   always #13 osc_wave_i[2] = ~osc_wave_i[2];
   always #15 osc_wave_i[1] = ~osc_wave_i[1];
   always #17 osc_wave_i[0] = ~osc_wave_i[0];

   psr_core_model core (.sys_clk_i(sys_clk_i), .ps_rd_o(ps_rd), .ps_wr_o(ps_wr),
      .ps_num_o(ps_num), .ps_wdata_o(ps_wdata), .ps_ack_i(ps_ack_o),
      .ps_miss_i(ps_miss_o), .ps_rdata_i(ps_rdata_o));
   psr_bank #(.DIV_RATIO(DIVR)) dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
      .ps_rd_i(ps_rd), .ps_wr_i(ps_wr), .ps_num_i(ps_num), .ps_wdata_i(ps_wdata),
      .ps_ack_o(ps_ack_o), .ps_miss_o(ps_miss_o), .ps_rdata_o(ps_rdata_o),
      .event_req_i(event_req_i), .event_vec_i(event_vec_i), .dest_valid_o(dest_valid_o),
      .dest_addr_o(dest_addr_o), .all_paused_i(all_paused_i),
      .tile_clk_en_o(tile_clk_en_o), .clk_slow_o(clk_slow_o),
      .tile_number_i(tile_number_i), .otp_boot_en_i(otp_boot_en_i),
      .boot_mode_pin_i(boot_mode_pin_i), .security_load_i(security_load_i),
      .security_word_i(security_word_i), .osc_wave_i(osc_wave_i), .osc_run_o(osc_run_o),
      .debug_entry_i(debug_entry_i), .saved_status_word_i(saved_status_word_i));

   // Repeatable random source
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Writable bits of each register; all else reads zero
   function automatic logic [31:0] wmask(input logic [7:0] n);
      case (n)
         8'h00: return 32'hffff_fffc;
         8'h01: return 32'hffff_0000;
         8'h02: return 32'h0000_0030;
         8'h06: return 32'h0000_0003;
         default: return 32'h0;
      endcase
   endfunction

   task automatic acc(input logic wr, input logic [7:0] n, input logic [31:0] wd,
                      output logic [31:0] rd, output logic miss);
      logic ack;
      core.access(wr, n, wd, rd, miss, ack);
      `CHK("ack", 1'b1, ack)
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask

   task automatic pulse_reset();
      nrst_i = 1'b0;
      cyc(3);
      nrst_i = 1'b1;
      cyc(4);
   endtask

   task automatic read_osc(output logic [15:0] v[4]);
      for (int k = 0; k < 4; k++) begin
         acc(1'b0, 8'h07 + 8'(k), 32'h0, g, m);
         `CHK("osc upper", 16'h0, g[31:16])
         v[k] = g[15:0];
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      #100000;
      err_count++;
      give_verdict();
   end

   initial begin
      tile_number_i = 8'(xs());
      boot_mode_pin_i = 8'(xs());
      otp_boot_en_i = 1'b1;
      pulse_reset();
      // Reset values and boot status
      acc(1'b0, 8'h00, 32'h0, g, m);
      `CHK("ram base", 32'h0001_0000, g)
      acc(1'b1, 8'h03, 32'hffff_ffff, g, m);
      acc(1'b0, 8'h03, 32'h0, g, m);
      `CHK("boot", {8'h0, tile_number_i, 7'h0, 1'b1, boot_mode_pin_i}, g)
      $display("test reset_boot done");
      // Random writes, masked read back
      for (int i = 0; i < 12; i++) begin
         d = xs();
         acc(1'b1, wregs[i % 4], d, g, m);
         acc(1'b0, wregs[i % 4], 32'h0, g, m);
         `CHK("rw", d & wmask(wregs[i % 4]), g)
         `CHK("miss", 1'b0, m)
         if (wregs[i % 4] == 8'h06)
            `CHK("run", {d[1], d[1], d[0], d[0]}, osc_run_o)
      end
      foreach (holes[i]) begin
         acc(1'b0, holes[i], 32'h0, g, m);
         `CHK("hole miss", 1'b1, m)
         `CHK("hole data", 32'h0, g)
      end
      $display("test rw_map done");
      // Security copy, saved status, vector formation
      d = xs();
      security_word_i = d;
      security_load_i = 1'b1;
      saved_status_word_i = ~d;
      debug_entry_i = 1'b1;
      cyc(1);
      security_load_i = 1'b0;
      debug_entry_i = 1'b0;
      acc(1'b1, 8'h05, 32'h0, g, m);
      acc(1'b0, 8'h05, 32'h0, g, m);
      `CHK("security", d, g)
      acc(1'b0, 8'h10, 32'h0, g, m);
      `CHK("saved", ~d, g)
      for (int i = 0; i < 4; i++) begin
         d = xs();
         acc(1'b1, 8'h01, d, g, m);
         event_vec_i = 16'(xs());
         event_req_i = 1'b1;
         cyc(1);
         event_req_i = 1'b0;
         `CHK("dest valid", 1'b1, dest_valid_o)
         `CHK("dest", {d[31:16], event_vec_i}, dest_addr_o)
      end
      $display("test copy_event done");
      // Divider in static and dynamic mode
      for (int md = 0; md < 3; md++) begin
         all_paused_i = (md == 2);
         acc(1'b1, 8'h02, (md == 0) ? 32'h10 : 32'h30, g, m);
         cyc(3);
         `CHK("slow", md != 1, clk_slow_o)
         cnt = 0;
         repeat (4 * DIVR) begin
            cyc(1);
            cnt += int'(tile_clk_en_o);
         end
         `CHK("enables", (md == 1) ? 4 * DIVR : 4, cnt)
      end
      acc(1'b1, 8'h02, 32'h0, g, m);
      cyc(3);
      `CHK("slow off", 1'b0, clk_slow_o)
      $display("test divider done");
      // Oscillators: run all, then only the peripheral pair
      acc(1'b1, 8'h06, 32'h3, g, m);
      cyc(50);
      acc(1'b1, 8'h06, 32'h0, g, m);
      cyc(10);
      read_osc(b);
      acc(1'b1, 8'h06, 32'h1, g, m);
      cyc(100);
      acc(1'b1, 8'h06, 32'h0, g, m);
      cyc(10);
      read_osc(a);
      `CHK("tile cell", b[0], a[0])
      `CHK("tile wire", b[1], a[1])
      // Window of about 102 cycles against wave periods of 30 and 34 ns
      `CHK("pcell", 1'b1, (a[2] - b[2]) inside {[16'd11 : 16'd17]})
      `CHK("pwire", 1'b1, (a[3] - b[3]) inside {[16'd9 : 16'd15]})
      pulse_reset();
      read_osc(b);
      for (int k = 0; k < 4; k++)
         `CHK("kept", a[k], b[k])
      acc(1'b0, 8'h00, 32'h0, g, m);
      `CHK("ram base again", 32'h0001_0000, g)
      acc(1'b0, 8'h06, 32'h0, g, m);
      `CHK("osc ctl reset", 32'h0, g)
      otp_boot_en_i = 1'b0;
      acc(1'b0, 8'h03, 32'h0, g, m);
      `CHK("boot again", {8'h0, tile_number_i, 8'h0, boot_mode_pin_i}, g)
      $display("test oscillators done");
      give_verdict();
   end
endmodule
